// file: hw/wtu_watch_unit.sv
`timescale 1ns/1ns
// Summary of operation
// - PC sample register unknown after reset
// - Real PC samples read with bit 0 zero
// - Without sampling, PC sample reads zero, ignores writes
// - PC sample occupies full 32 bits
// - One 32-bit reference register per comparator
// - Reference and mask size unknown after reset
// - Only comparators below count are implemented
// - Mask size in bits 4:0, rest reserved
// - Mask writes clamp to supported maximum size
// - Read-only match flag at function bit 24
// - Function read clears match flag after returning
// - Action select in function bits 3:0
// - Reset clears every action select to zero
// - Function bits 31:25 and 23:4 reserved
// - 0000 disables, 0100 matches instruction address
// - 0101/0110/0111 match data reads, writes, both
// - Masked data address equals size-aligned reference, masked instruction address equals reference
module wtu_watch_unit #(
  parameter int NUM_COMP = 4,
  parameter logic [4:0] MASK_MAX = 5'h1F,
  parameter bit PC_SAMPLE_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Debug access port register access
  input wire logic dap_sel_in,
  input wire logic dap_write_in,
  input wire logic [11:0] dap_addr_in,
  input wire logic [31:0] dap_wdata_in,
  output logic [31:0] dap_rdata_out,
  output logic dap_rvalid_out,
  // Executed instruction address stream
  input wire logic exec_valid_in,
  input wire logic [31:0] exec_addr_in,
  input wire logic sample_blocked_in,
  // Instruction address monitor
  input wire logic iaddr_valid_in,
  input wire logic [31:0] iaddr_in,
  // Data access monitor
  input wire logic daddr_valid_in,
  input wire logic [31:0] daddr_in,
  input wire logic daddr_read_in,
  input wire logic [1:0] daddr_size_in,
  // Watchpoint events, one per comparator
  output logic [NUM_COMP-1:0] pc_watch_event_out,
  output logic [NUM_COMP-1:0] data_watch_event_out
);

  localparam logic [3:0] COUNT_VAL = 4'(NUM_COMP);

  // Per-comparator storage
  logic [31:0] comparator_reference_reg [NUM_COMP];
  logic [4:0] comparator_mask_size_reg [NUM_COMP];
  logic [3:0] comparator_action_select_reg [NUM_COMP];
  logic [NUM_COMP-1:0] matched_reg;
  logic [31:0] executed_addr_sample_reg;
  logic sample_seen_reg;

  // Match and register decode
  logic [NUM_COMP-1:0] imatch;
  logic [NUM_COMP-1:0] dmatch;
  logic [NUM_COMP-1:0] ref_wr;
  logic [NUM_COMP-1:0] mask_wr;
  logic [NUM_COMP-1:0] func_wr;
  logic [NUM_COMP-1:0] func_rd;
  logic [NUM_COMP-1:0] ref_hit;
  logic [NUM_COMP-1:0] mask_hit;
  logic [NUM_COMP-1:0] func_hit;
  logic [NUM_COMP-1:0] flag_set;
  // Read path
  logic [31:0] rdata_next;
  logic [31:0] pc_word;
  logic dap_rd;
  logic dap_wr;
  logic ctrl_hit;
  logic pc_hit;

  // Ones in the low bits given by a mask size
  function automatic logic [31:0] low_ones(input logic [4:0] size);
    low_ones = ~(32'hFFFF_FFFF << size);
  endfunction

  // Address-decoded hit on one comparator register
  function automatic logic cmp_hit(input logic [11:0] addr, input int idx,
                                   input logic [11:0] ofs);
    logic [11:0] base;
    base = wtu_pkg::OFS_CMP_BASE + 12'(idx << wtu_pkg::STRIDE_LSB) + ofs;
    cmp_hit = (addr == base);
  endfunction

  // Reference aligned down to the access size
  function automatic logic [31:0] align_ref(input logic [31:0] ref_val,
                                            input logic [1:0] size);
    logic [31:0] r;
    r = ref_val;
    case (size)
      wtu_pkg::SIZE_HALF: r[0] = 1'b0;
      wtu_pkg::SIZE_WORD: r[1:0] = 2'h0;
      default: r = ref_val;
    endcase
    align_ref = r;
  endfunction

  // Data access kinds watched by an action
  function automatic logic data_kind_sel(input logic [3:0] act, input logic is_read);
    logic sel;
    sel = 1'b0;
    case (act)
      wtu_pkg::ACT_DADDR_RD: sel = is_read;
      wtu_pkg::ACT_DADDR_WR: sel = !is_read;
      wtu_pkg::ACT_DADDR_RW: sel = 1'b1;
      default: sel = 1'b0; // Disabled, instruction or reserved
    endcase
    data_kind_sel = sel;
  endfunction

  // Mask size limited to the supported range
  function automatic logic [4:0] clamp_mask(input logic [4:0] req);
    logic [4:0] size;
    size = req;
    if (req > MASK_MAX) begin
      size = MASK_MAX;
    end
    clamp_mask = size;
  endfunction

  // Function register image, reserved bits zero
  function automatic logic [31:0] func_word(input logic flag, input logic [3:0] act);
    logic [31:0] w;
    w = wtu_pkg::WORD_ZERO;
    w[wtu_pkg::MATCHED_BIT] = flag;
    w[wtu_pkg::ACT_W-1:0] = act;
    func_word = w;
  endfunction

  // Mask register image, reserved bits zero
  function automatic logic [31:0] mask_word(input logic [4:0] size);
    logic [31:0] w;
    w = wtu_pkg::WORD_ZERO;
    w[wtu_pkg::MASK_W-1:0] = size;
    mask_word = w;
  endfunction

  // Control register image, count in the top field
  function automatic logic [31:0] ctrl_word();
    logic [31:0] w;
    w = wtu_pkg::WORD_ZERO;
    w[wtu_pkg::COUNT_LSB +: wtu_pkg::COUNT_W] = COUNT_VAL;
    ctrl_word = w;
  endfunction

  // Pc sample image: zero when absent, all ones when invalid
  function automatic logic [31:0] pc_read(input logic blocked, input logic seen,
                                          input logic [31:0] sample);
    logic [31:0] w;
    w = wtu_pkg::PC_INVALID;
    if (!PC_SAMPLE_EN) begin
      w = wtu_pkg::WORD_ZERO;
    end else if (seen && !blocked) begin
      w = sample;
    end
    pc_read = w;
  endfunction

  // Access kind and fixed-register decode
  assign dap_rd = dap_sel_in && !dap_write_in;
  assign dap_wr = dap_sel_in && dap_write_in;
  assign ctrl_hit = (dap_addr_in == wtu_pkg::OFS_CONTROL);
  assign pc_hit = (dap_addr_in == wtu_pkg::OFS_PC_SAMPLE);

  // Comparator decode; indices at or above the count decode nothing
  always_comb begin
    for (int i = 0; i < NUM_COMP; i++) begin
      ref_hit[i] = cmp_hit(dap_addr_in, i, wtu_pkg::OFS_REF);
      mask_hit[i] = cmp_hit(dap_addr_in, i, wtu_pkg::OFS_MASK);
      func_hit[i] = cmp_hit(dap_addr_in, i, wtu_pkg::OFS_FUNC);
    end
  end

  // Register strobes; writes to control and pc sample are dropped
  always_comb begin
    for (int i = 0; i < NUM_COMP; i++) begin
      ref_wr[i] = dap_wr && ref_hit[i];
      mask_wr[i] = dap_wr && mask_hit[i];
      func_wr[i] = dap_wr && func_hit[i];
      func_rd[i] = dap_rd && func_hit[i];
    end
  end

  // Instruction address matching
  always_comb begin
    logic [31:0] m;
    m = wtu_pkg::WORD_ZERO;
    for (int i = 0; i < NUM_COMP; i++) begin
      m = low_ones(comparator_mask_size_reg[i]);
      imatch[i] = iaddr_valid_in &&
                  (comparator_action_select_reg[i] == wtu_pkg::ACT_IADDR) &&
                  ((iaddr_in & ~m) == comparator_reference_reg[i]);
    end
  end

  // Data address matching, reference aligned to the access size
  always_comb begin
    logic [31:0] m;
    m = wtu_pkg::WORD_ZERO;
    for (int i = 0; i < NUM_COMP; i++) begin
      m = low_ones(comparator_mask_size_reg[i]);
      dmatch[i] = daddr_valid_in &&
                  data_kind_sel(comparator_action_select_reg[i], daddr_read_in) &&
                  ((daddr_in & ~m) ==
                   align_ref(comparator_reference_reg[i], daddr_size_in));
    end
  end

  // Either kind of match raises the flag
  assign flag_set = imatch | dmatch;

  // Reference values, no reset
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_COMP; i++) begin
      if (ref_wr[i]) begin
        comparator_reference_reg[i] <= dap_wdata_in;
      end
    end
  end

  // Mask sizes, no reset, clamped to the supported range
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NUM_COMP; i++) begin
      if (mask_wr[i]) begin
        comparator_mask_size_reg[i] <= clamp_mask(dap_wdata_in[wtu_pkg::MASK_W-1:0]);
      end
    end
  end

  // Action select, cleared by reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_COMP; i++) begin
        comparator_action_select_reg[i] <= wtu_pkg::ACT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_COMP; i++) begin
        if (func_wr[i]) begin
          comparator_action_select_reg[i] <= dap_wdata_in[wtu_pkg::ACT_W-1:0];
        end
      end
    end
  end

  // Sticky match flags, set beats clear-on-read
  // Set wins so a match during a read is never lost
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      matched_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_COMP; i++) begin
        if (flag_set[i]) begin
          matched_reg[i] <= 1'b1;
        end else if (func_rd[i]) begin
          matched_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Instruction watchpoint event pulses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_watch_event_out <= '0;
    end else begin
      pc_watch_event_out <= imatch;
    end
  end

  // Data watchpoint event pulses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_watch_event_out <= '0;
    end else begin
      data_watch_event_out <= dmatch;
    end
  end

  // Program counter sample, content unknown until first sample
  always_ff @(posedge clk_in) begin
    if (exec_valid_in) begin
      executed_addr_sample_reg <= exec_addr_in;
    end
  end

  // First sample since reset makes the register valid
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sample_seen_reg <= 1'b0;
    end else if (exec_valid_in) begin
      sample_seen_reg <= 1'b1;
    end
  end

  // Sample as read back, bit 0 forced low
  always_comb begin
    pc_word = executed_addr_sample_reg;
    pc_word[wtu_pkg::PC_LSB_BIT] = 1'b0;
  end

  // Read mux
  always_comb begin
    rdata_next = wtu_pkg::WORD_ZERO;
    if (ctrl_hit) begin
      rdata_next = ctrl_word();
    end else if (pc_hit) begin
      rdata_next = pc_read(sample_blocked_in, sample_seen_reg, pc_word);
    end
    // Comparators beyond the count decode nothing and read zero
    for (int i = 0; i < NUM_COMP; i++) begin
      if (ref_hit[i]) begin
        rdata_next = comparator_reference_reg[i];
      end else if (mask_hit[i]) begin
        rdata_next = mask_word(comparator_mask_size_reg[i]);
      end else if (func_hit[i]) begin
        rdata_next = func_word(matched_reg[i], comparator_action_select_reg[i]);
      end
    end
  end

  // Read answer valid one cycle after the request
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dap_rvalid_out <= 1'b0;
    end else begin
      dap_rvalid_out <= dap_rd;
    end
  end

  // Read data, old flag value returned before the clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dap_rdata_out <= wtu_pkg::WORD_ZERO;
    end else if (dap_rd) begin
      dap_rdata_out <= rdata_next;
    end
  end

endmodule

// file: hw/wtu_pkg.sv
package wtu_pkg;
  // Register offsets within the unit, byte addresses
  localparam logic [11:0] OFS_CONTROL = 12'h0000;
  localparam logic [11:0] OFS_PC_SAMPLE = 12'h001C;
  localparam logic [11:0] OFS_CMP_BASE = 12'h0020;
  localparam logic [11:0] OFS_CMP_STRIDE = 12'h0010;
  localparam logic [11:0] OFS_REF = 12'h0000;
  localparam logic [11:0] OFS_MASK = 12'h0004;
  localparam logic [11:0] OFS_FUNC = 12'h0008;
  localparam int ADDR_W = 12;
  localparam int STRIDE_LSB = 4;

  // Field layouts
  localparam int COUNT_LSB = 28;
  localparam int COUNT_W = 4;
  localparam int MASK_W = 5;
  localparam int ACT_W = 4;
  localparam int MATCHED_BIT = 24;
  localparam int PC_LSB_BIT = 0;

  // Values
  localparam logic [31:0] PC_INVALID = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [4:0] MASK_ALL_ONES = 5'h1F;
  localparam logic [3:0] ACT_RESET = 4'h0;

  // Action-select encodings
  localparam logic [3:0] ACT_DISABLED = 4'h0;
  localparam logic [3:0] ACT_IADDR = 4'h4;
  localparam logic [3:0] ACT_DADDR_RD = 4'h5;
  localparam logic [3:0] ACT_DADDR_WR = 4'h6;
  localparam logic [3:0] ACT_DADDR_RW = 4'h7;

  // Data access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage

// file: bench/wtu_monitor.sv
`timescale 1ns/1ns
module wtu_monitor #(
  parameter int NUM_COMP = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Access port
  input wire logic dap_sel_in,
  input wire logic dap_write_in,
  input wire logic [11:0] dap_addr_in,
  input wire logic [31:0] dap_rdata_out,
  input wire logic dap_rvalid_out,
  // Monitors and events
  input wire logic sample_blocked_in,
  input wire logic iaddr_valid_in,
  input wire logic daddr_valid_in,
  input wire logic [NUM_COMP-1:0] pc_watch_event_out,
  input wire logic [NUM_COMP-1:0] data_watch_event_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic rd;
  assign rd = dap_sel_in && !dap_write_in;
  sequence s_func_rd;
    rd && dap_addr_in >= 12'h020 && dap_addr_in[3:0] == 4'h8;
  endsequence
  // Same register two cycles later, no monitored access in between
  sequence s_quiet_rd;
    rd && dap_addr_in == $past(dap_addr_in, 2) && !$past(iaddr_valid_in) &&
      !$past(daddr_valid_in) && !$past(iaddr_valid_in, 2) && !$past(daddr_valid_in, 2);
  endsequence
  a_read_answered: assert property (rd |=> dap_rvalid_out)
    else $error("read not answered next cycle");
  a_answer_only_read: assert property (!rd |=> !dap_rvalid_out)
    else $error("answer without read");
  a_read_clears: assert property (s_func_rd ##2 s_quiet_rd |=> !dap_rdata_out[24])
    else $error("match flag not cleared by read");
  a_pc_lsb_zero: assert property (rd && dap_addr_in == 12'h01C |=>
    dap_rdata_out == 32'hFFFF_FFFF || !dap_rdata_out[0])
    else $error("pc sample bit 0 set");
  a_pc_blocked: assert property (rd && dap_addr_in == 12'h01C && sample_blocked_in |=>
    dap_rdata_out == 32'hFFFF_FFFF)
    else $error("blocked pc sample not all ones");
  a_func_reserved: assert property (s_func_rd |=>
    dap_rdata_out[31:25] == 7'h00 && dap_rdata_out[23:4] == 20'h0_0000)
    else $error("function reserved bits not zero");
  a_mask_reserved: assert property (rd && dap_addr_in >= 12'h020 &&
    dap_addr_in[3:0] == 4'h4 |=> dap_rdata_out[31:5] == 27'h000_0000)
    else $error("mask reserved bits not zero");
  a_pc_event_cause: assert property (|pc_watch_event_out |-> $past(iaddr_valid_in))
    else $error("pc event without instruction access");
  a_data_event_cause: assert property (|data_watch_event_out |-> $past(daddr_valid_in))
    else $error("data event without data access");
  a_ctrl_count: assert property (rd && dap_addr_in == 12'h000 |=>
    dap_rdata_out[31:28] == NUM_COMP[3:0])
    else $error("comparator count wrong");
endmodule
bind wtu_watch_unit wtu_monitor #(.NUM_COMP(NUM_COMP)) mon (.clk_in, .nrst_in, .dap_sel_in,
  .dap_write_in, .dap_addr_in, .dap_rdata_out, .dap_rvalid_out, .sample_blocked_in,
  .iaddr_valid_in, .daddr_valid_in, .pc_watch_event_out, .data_watch_event_out);

// file: bench/wtu_dbg_model.sv
`timescale 1ns/1ns
module wtu_dbg_model (
  // Clock
  input wire logic clk_in,
  // Access port
  output logic dap_sel_out,
  output logic dap_write_out,
  output logic [11:0] dap_addr_out,
  output logic [31:0] dap_wdata_out,
  input wire logic [31:0] dap_rdata_in,
  input wire logic dap_rvalid_in
);
  initial begin
    dap_sel_out = 1'b0;
    dap_write_out = 1'b0;
    dap_addr_out = 12'h000;
    dap_wdata_out = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    #1;
    dap_sel_out = 1'b1;
    dap_write_out = w;
    dap_addr_out = a;
    dap_wdata_out = d;
    @(posedge clk_in);
    #1;
    q = dap_rvalid_in ? dap_rdata_in : 32'hxxxx_xxxx;
    dap_sel_out = 1'b0;
    // Released lines carry no stale value
    dap_addr_out = ~a;
    dap_wdata_out = ~d;
  endtask
endmodule

// file: bench/wtu_watch_unit_tb.sv
`timescale 1ns/1ns
module wtu_watch_unit_tb;
  logic clk_in, nrst_in, dap_sel_in, dap_write_in, dap_rvalid_out, exec_valid_in;
  logic sample_blocked_in, iaddr_valid_in, daddr_valid_in, daddr_read_in, exp, miss;
  logic [11:0] dap_addr_in;
  logic [31:0] dap_wdata_in, dap_rdata_out, exec_addr_in, iaddr_in, daddr_in, q, r, a;
  logic [1:0] daddr_size_in;
  logic [3:0] pc_watch_event_out, data_watch_event_out, act, e;
  int n_mismatch, check_count, cycles, n, k;
  integer seed;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  wtu_watch_unit #(.NUM_COMP(4), .MASK_MAX(5'h1F), .PC_SAMPLE_EN(1'b1)) uut (.clk_in, .nrst_in,
    .dap_sel_in, .dap_write_in, .dap_addr_in, .dap_wdata_in, .dap_rdata_out, .dap_rvalid_out,
    .exec_valid_in, .exec_addr_in, .sample_blocked_in, .iaddr_valid_in, .iaddr_in,
    .daddr_valid_in, .daddr_in, .daddr_read_in, .daddr_size_in, .pc_watch_event_out,
    .data_watch_event_out);
  wtu_dbg_model dbg (.clk_in(clk_in), .dap_sel_out(dap_sel_in), .dap_write_out(dap_write_in),
    .dap_addr_out(dap_addr_in), .dap_wdata_out(dap_wdata_in), .dap_rdata_in(dap_rdata_out),
    .dap_rvalid_in(dap_rvalid_out));
  function automatic logic [11:0] fa(input int c, input int off);
    return 12'(32'h20 + 16 * c + off);
  endfunction
  // Kind 0 instruction, 1 data read, 2 data write
  function automatic logic hit(input logic [3:0] ac, input int kd);
    return (ac == 4'h4 && kd == 0) || (ac == 4'h5 && kd == 1) || (ac == 4'h6 && kd == 2)
      || (ac == 4'h7 && kd != 0);
  endfunction
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic rd(input logic [11:0] ad);
    dbg.xfer(1'b0, ad, 32'h0000_0000, q);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    dbg.xfer(1'b1, ad, d, q);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    seed = 38482;
    {exec_valid_in, sample_blocked_in, iaddr_valid_in, daddr_valid_in, daddr_read_in} = 5'h00;
    {exec_addr_in, iaddr_in, daddr_in, daddr_size_in} = 98'h0;
    nrst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    for (int c = 0; c < 5; c++) begin
      rd(fa(c, 8));
      chk("func reset", 32'h0000_0000, q);
      r = $random(seed);
      wr(fa(c, 0), r);
      rd(fa(c, 0));
      chk("reference", (c < 4) ? r : 32'h0000_0000, q);
      wr(fa(c, 4), 32'hFFFF_FFFF);
      rd(fa(c, 4));
      chk("mask size", (c < 4) ? 32'h0000_001F : 32'h0000_0000, q);
      wr(fa(c, 8), 32'hFFFF_FFF7);
      rd(fa(c, 8));
      chk("action", (c < 4) ? 32'h0000_0007 : 32'h0000_0000, q);
      wr(fa(c, 8), 32'h0000_0000);
    end
    exec_addr_in = $random(seed) | 32'h0000_0001;
    exec_valid_in = 1'b1;
    @(posedge clk_in);
    #1 exec_valid_in = 1'b0;
    rd(12'h01C);
    chk("pc sample", exec_addr_in & 32'hFFFF_FFFE, q);
    sample_blocked_in = 1'b1;
    rd(12'h01C);
    chk("pc blocked", 32'hFFFF_FFFF, q);
    sample_blocked_in = 1'b0;
    rd(12'h000);
    chk("count", 32'h0000_0004, {28'h0, q[31:28]});
    for (int i = 0; i < 15; i++) begin
      n = i % 4;
      k = i % 3;
      act = (i < 3) ? 4'h0 : 4'(3 + i / 3);
      a = $random(seed);
      miss = a[12];
      r = $random(seed) & 32'hFFFF_FF00;
      wr(fa(n, 0), r);
      wr(fa(n, 4), 32'h0000_0008);
      wr(fa(n, 8), {28'h0, act});
      a = (r | {24'h0, a[7:0]}) ^ {23'h0, miss, 8'h00};
      exp = hit(act, k) && !miss;
      e = exp ? 4'(1 << n) : 4'h0;
      {iaddr_in, daddr_in, daddr_size_in} = {a, a, 2'(a[11:10] % 2'd3)};
      {iaddr_valid_in, daddr_valid_in, daddr_read_in} = {k == 0, k != 0, k == 1};
      @(posedge clk_in);
      #1 {iaddr_valid_in, daddr_valid_in} = 2'b00;
      chk("pc event", {28'h0, (k == 0) ? e : 4'h0}, {28'h0, pc_watch_event_out});
      chk("data event", {28'h0, (k != 0) ? e : 4'h0}, {28'h0, data_watch_event_out});
      rd(fa(n, 8));
      chk("match flag", {7'h00, exp, 20'h0_0000, act}, q);
      rd(fa(n, 8));
      chk("flag cleared", {28'h0, act}, q);
      wr(fa(n, 8), 32'h0000_0000);
    end
    give_verdict();
  end
endmodule
